// *** design/dsc_pkg.sv ***
// Shared constants and types of the drive state control block.
// Assumes one system clock; object indexes are the addresses seen on the object port.
package dsc_pkg;

    // Object indexes of the three dictionary entries
    localparam logic [15:0] IDX_CONTROL   = 16'h6040;
    localparam logic [15:0] IDX_STATUS    = 16'h6041;
    localparam logic [15:0] IDX_QS_OPTION = 16'h605A;

    // Reset values
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] QS_RESET   = 16'h0000;

    // Control word bit positions
    localparam int CW_SWITCH_ON   = 0;
    localparam int CW_VOLTAGE     = 1;
    localparam int CW_QUICK_N     = 2;
    localparam int CW_ENABLE      = 3;
    localparam int CW_NEW_SETPT   = 4;
    localparam int CW_IMMEDIATE   = 5;
    localparam int CW_RELATIVE    = 6;
    localparam int CW_FAULT_RESET = 7;
    localparam int CW_HALT        = 8;

    // Status word bit positions above the state bits
    localparam int SW_WARNING = 7;
    localparam int SW_TARGET  = 10;
    localparam int SW_MODE_12 = 12;
    localparam int SW_MODE_13 = 13;

    // Status word state patterns, bits 6..0
    localparam logic [6:0] SP_NOT_READY = 7'h00;
    localparam logic [6:0] SP_SOD       = 7'h40;
    localparam logic [6:0] SP_READY     = 7'h21;
    localparam logic [6:0] SP_SWITCHED  = 7'h23;
    localparam logic [6:0] SP_OP_EN     = 7'h27;
    localparam logic [6:0] SP_QUICK     = 7'h07;
    localparam logic [6:0] SP_F_REACT   = 7'h0F;
    localparam logic [6:0] SP_FAULT     = 7'h08;
    localparam int         SP_VOLT_BIT  = 4;

    // Modes of operation
    localparam logic [7:0] MODE_PROFILE_POS = 8'h01;
    localparam logic [7:0] MODE_PROFILE_VEL = 8'h03;
    localparam logic [7:0] MODE_HOMING      = 8'h06;
    localparam logic [7:0] MODE_INTERP      = 8'h07;

    // Quick-stop option values
    localparam logic [15:0] QS_OPT_COAST      = 16'h0000;
    localparam logic [15:0] QS_OPT_QUICK      = 16'h0001;
    localparam logic [15:0] QS_OPT_SLOW       = 16'h0002;
    localparam logic [15:0] QS_OPT_QUICK_HOLD = 16'h0003;
    localparam logic [15:0] QS_OPT_SLOW_HOLD  = 16'h0004;

    // Panel indication kinds
    localparam logic [2:0] PANEL_RESET_IND = 3'h0;
    localparam logic [2:0] PANEL_READY_IND = 3'h1;
    localparam logic [2:0] PANEL_RUN_IND   = 3'h2;
    localparam logic [2:0] PANEL_FAULT_IND = 3'h3;
    localparam logic [2:0] PANEL_VARIABLE  = 3'h4;

    typedef enum {
        ST_NOT_READY, ST_SWITCH_ON_DISABLED, ST_READY, ST_SWITCHED_ON,
        ST_OP_ENABLED, ST_QUICK_STOP, ST_FAULT_REACTION, ST_FAULT
    } dsc_state_t;

    typedef enum {
        CMD_NONE, CMD_SHUTDOWN, CMD_SWITCH_ON, CMD_ENABLE_OP,
        CMD_DISABLE_VOLTAGE, CMD_QUICK_STOP
    } dsc_cmd_t;

    typedef enum logic [1:0] {STOP_NONE, STOP_COAST, STOP_QUICK, STOP_SLOW} dsc_stop_t;

endpackage

// *** design/dsc_panel_if.sv ***
// Signals between the state machine and the panel indication encoder.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface dsc_panel_if
    import dsc_pkg::*;
#(
    parameter int FAULT_CODE_W = 12,
    parameter int PANEL_SEL_W  = 8
);
    dsc_state_t              state;
    logic [FAULT_CODE_W-1:0] faultCode;
    logic [PANEL_SEL_W-1:0]  varSelect;
    logic [15:0]             varValue;
    logic [2:0]              panelKind;
    logic [15:0]             panelValue;

    modport control (output state, faultCode, varSelect, varValue,
                     input panelKind, panelValue);
    modport panel   (input state, faultCode, varSelect, varValue,
                     output panelKind, panelValue);
endinterface
`default_nettype wire

// *** design/dsc_panel_display.sv ***
// Front-panel indication encoder: picks the indication kind and value.
// Assumes state and selections are on sys_clk; outputs are registered.
`timescale 1ns/1ps
`default_nettype none
module dsc_panel_display
    import dsc_pkg::*;
#(
    parameter int FAULT_CODE_W = 12
)
(
    input  wire logic   sys_clk,
    input  wire logic   reset,
    dsc_panel_if.panel  pif
);
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            pif.panelKind  <= PANEL_RESET_IND;                // see R1
            pif.panelValue <= 16'h0000;
        end
        else if (pif.state == ST_FAULT || pif.state == ST_FAULT_REACTION)
        begin
            pif.panelKind  <= PANEL_FAULT_IND;                // see R4
            pif.panelValue <= 16'(pif.faultCode);
        end
        else if (pif.varSelect != '0)
        begin
            // User variable replaces the state indication outside fault
            pif.panelKind  <= PANEL_VARIABLE;                 // see R5
            pif.panelValue <= pif.varValue;
        end
        else
        begin
            pif.panelValue <= 16'h0000;
            unique case (pif.state)
                ST_NOT_READY:                pif.panelKind <= PANEL_RESET_IND; // see R1
                ST_OP_ENABLED, ST_QUICK_STOP: pif.panelKind <= PANEL_RUN_IND;  // see R3
                default:                     pif.panelKind <= PANEL_READY_IND; // see R2
            endcase
        end
    end
endmodule
`default_nettype wire

// *** design/dsc_drive_state_control.sv ***
// Drive power-state machine driven by the control word object.
// Assumes object port and motion signals on sys_clk; init/fault pins are asynchronous.
// How it works
// R1 - Power-on or reset starts in reset state
// R2 - Ready state after init with no hardware fault
// R3 - Enabled energised drive shows running indication
// R4 - Fault shows error indication with fault code
// R5 - Panel variable select overrides non-fault indication
// R6 - Control word bits decoded per fixed layout
// R7 - Master enables by writing 6, 7, 15
// R8 - Writing 7 drops out of operation enabled
// R9 - Profile position: start edge, immediate, relative
// R10 - Homing start/stop on edges; other modes ignore
// R11 - Status word carries state, warning, target reached
// R12 - Status bits 12 and 13 depend on mode
// R13 - Low status bits encode the idle states
// R14 - Operation enabled shows x01x 0111
// R15 - Quick stop active shows x00x 0111
// R16 - Fault reaction 1111, fault 1000 patterns
// R17 - Option 0 coasts; 1,2 stop then disable
// R18 - Options 3,4 stop and remain in quick stop
// R19 - Value 2 when enabled quick stops; options 0-2 then disable
// R20 - Writes change state only, power stage internal
// R21 - Rising fault reset clears fault if gone
// R22 - Illegal state requests are ignored
`timescale 1ns/1ps
`default_nettype none
module dsc_drive_state_control
    import dsc_pkg::*;
#(
    parameter int FAULT_CODE_W = 12,
    parameter int PANEL_SEL_W  = 8
)
(
    input  wire logic                    sys_clk,
    input  wire logic                    reset,
    input  wire logic                    objWrite,
    input  wire logic                    objRead,
    input  wire logic [15:0]             objIndex,
    input  wire logic [15:0]             objWriteData,
    output logic [15:0]                  objReadData,
    output logic                         objAck,
    input  wire logic                    initDone,
    input  wire logic                    hwFault,
    input  wire logic                    faultPresent,
    input  wire logic [FAULT_CODE_W-1:0] faultCode,
    input  wire logic                    warning,
    input  wire logic [7:0]              modeOfOperation,
    input  wire logic                    targetReached,
    input  wire logic                    setpointAck,
    input  wire logic                    homingAttained,
    input  wire logic                    homingError,
    input  wire logic                    followingError,
    input  wire logic                    interpActive,
    input  wire logic                    zeroSpeed,
    input  wire logic                    stopDone,
    input  wire logic [PANEL_SEL_W-1:0]  panelVariableSelect,
    input  wire logic [15:0]             panelVariableValue,
    output logic [15:0]                  statusWord,
    output logic [1:0]                   stopKind,
    output logic                         faultReaction,
    output logic                         energised,
    output logic                         moveStart,
    output logic                         setImmediate,
    output logic                         relativeTarget,
    output logic                         homingStart,
    output logic                         homingStop,
    output logic                         haltRequest,
    output logic [2:0]                   panelKind,
    output logic [15:0]                  panelValue
);
    if (FAULT_CODE_W < 1 || FAULT_CODE_W > 16)
    begin : g_bad_fault_w
        $error("FAULT_CODE_W must be 1 to 16");
    end
    if (PANEL_SEL_W < 1 || PANEL_SEL_W > 16)
    begin : g_bad_sel_w
        $error("PANEL_SEL_W must be 1 to 16");
    end

    // Command decode; 0111 means switch on or disable operation by state
    function automatic dsc_cmd_t decodeCmd(input logic [15:0] cw);
        dsc_cmd_t c;
        c = CMD_NONE;
        if (!cw[CW_VOLTAGE])
            c = CMD_DISABLE_VOLTAGE;
        else if (!cw[CW_QUICK_N])
            c = CMD_QUICK_STOP;
        else if (!cw[CW_SWITCH_ON])
            c = CMD_SHUTDOWN;
        else if (!cw[CW_ENABLE])
            c = CMD_SWITCH_ON;
        else
            c = CMD_ENABLE_OP;
        return c;
    endfunction

    // State pattern of the low seven status bits
    function automatic logic [6:0] statePattern(input dsc_state_t s);
        logic [6:0] p;
        p = SP_NOT_READY;
        unique case (s)
            ST_NOT_READY:          p = SP_NOT_READY;
            ST_SWITCH_ON_DISABLED: p = SP_SOD;
            ST_READY:              p = SP_READY;
            ST_SWITCHED_ON:        p = SP_SWITCHED;
            ST_OP_ENABLED:         p = SP_OP_EN;
            ST_QUICK_STOP:         p = SP_QUICK;
            ST_FAULT_REACTION:     p = SP_F_REACT;
            ST_FAULT:              p = SP_FAULT;
        endcase
        return p;
    endfunction

    // Asynchronous pins pass two flip-flops before any use
    logic [2:0] pinMeta_reg;
    logic [2:0] pinSync_reg;
    logic       initDoneS;
    logic       hwFaultS;
    logic       faultS;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            pinMeta_reg <= 3'h0;
            pinSync_reg <= 3'h0;
        end
        else
        begin
            pinMeta_reg <= {initDone, hwFault, faultPresent};
            pinSync_reg <= pinMeta_reg;
        end
    end

    assign initDoneS = pinSync_reg[2];
    assign hwFaultS  = pinSync_reg[1];
    assign faultS    = pinSync_reg[0];
    // Object registers
    logic [15:0] ctrlWord_reg;
    logic [15:0] ctrlPrev_reg;
    logic [15:0] qsOption_reg;
    logic [15:0] statusWord_reg;
    logic        ctrlHit;
    logic        qsHit;

    assign ctrlHit = objWrite && (objIndex == IDX_CONTROL);
    assign qsHit   = objWrite && (objIndex == IDX_QS_OPTION);

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            ctrlWord_reg <= CTRL_RESET;
        else if (ctrlHit)
            ctrlWord_reg <= objWriteData;                     // see R6
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            qsOption_reg <= QS_RESET;                         // see R17
        else if (qsHit)
            qsOption_reg <= objWriteData;
    end
    // Previous control word, for edge-triggered bits
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            ctrlPrev_reg <= CTRL_RESET;
        else
            ctrlPrev_reg <= ctrlWord_reg;
    end
    logic faultResetRise;
    logic setptRise;
    logic setptFall;

    assign faultResetRise = ctrlWord_reg[CW_FAULT_RESET] & ~ctrlPrev_reg[CW_FAULT_RESET];
    assign setptRise      = ctrlWord_reg[CW_NEW_SETPT] & ~ctrlPrev_reg[CW_NEW_SETPT];
    assign setptFall      = ~ctrlWord_reg[CW_NEW_SETPT] & ctrlPrev_reg[CW_NEW_SETPT];
    // Reads answer one cycle later; the status word is read-only
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            objReadData <= 16'h0000;
            objAck      <= 1'b0;
        end
        else
        begin
            objAck <= objWrite | objRead;
            if (objRead)
            begin
                unique case (objIndex)
                    IDX_CONTROL:   objReadData <= ctrlWord_reg;
                    IDX_STATUS:    objReadData <= statusWord_reg;  // see R11
                    IDX_QS_OPTION: objReadData <= qsOption_reg;
                    default:       objReadData <= 16'h0000;
                endcase
            end
        end
    end

    // State machine
    dsc_state_t state_reg;
    dsc_state_t state_next;
    dsc_cmd_t   cmd;
    logic       holdAfterStop;

    assign cmd           = decodeCmd(ctrlWord_reg);           // see R6
    assign holdAfterStop = (qsOption_reg == QS_OPT_QUICK_HOLD) ||
                           (qsOption_reg == QS_OPT_SLOW_HOLD);

    always_comb
    begin
        state_next = state_reg;                               // see R22
        if (faultS && state_reg != ST_NOT_READY &&
            state_reg != ST_FAULT_REACTION && state_reg != ST_FAULT)
            state_next = ST_FAULT_REACTION;                   // see R4
        else
        begin
            unique case (state_reg)
                ST_NOT_READY:
                    if (initDoneS && !hwFaultS)
                        state_next = ST_SWITCH_ON_DISABLED;   // see R2
                ST_SWITCH_ON_DISABLED:
                    if (cmd == CMD_SHUTDOWN)
                        state_next = ST_READY;                // see R7
                ST_READY:
                    if (cmd == CMD_SWITCH_ON)
                        state_next = ST_SWITCHED_ON;          // see R7
                    else if (cmd == CMD_DISABLE_VOLTAGE || cmd == CMD_QUICK_STOP)
                        state_next = ST_SWITCH_ON_DISABLED;
                ST_SWITCHED_ON:
                    if (cmd == CMD_ENABLE_OP)
                        state_next = ST_OP_ENABLED;           // see R7
                    else if (cmd == CMD_SHUTDOWN)
                        state_next = ST_READY;
                    else if (cmd == CMD_DISABLE_VOLTAGE || cmd == CMD_QUICK_STOP)
                        state_next = ST_SWITCH_ON_DISABLED;
                ST_OP_ENABLED:
                    if (cmd == CMD_SWITCH_ON)
                        state_next = ST_SWITCHED_ON;          // see R8
                    else if (cmd == CMD_QUICK_STOP)
                        state_next = ST_QUICK_STOP;           // see R19
                    else if (cmd == CMD_SHUTDOWN)
                        state_next = ST_READY;
                    else if (cmd == CMD_DISABLE_VOLTAGE)
                        state_next = ST_SWITCH_ON_DISABLED;
                ST_QUICK_STOP:
                    if (cmd == CMD_DISABLE_VOLTAGE)
                        state_next = ST_SWITCH_ON_DISABLED;
                    else if (holdAfterStop)
                    begin
                        // Held options return only on an enable request once stopDone is set
                        if (stopDone && cmd == CMD_ENABLE_OP)
                            state_next = ST_OP_ENABLED;       // see R18
                    end
                    else if (qsOption_reg == QS_OPT_QUICK || qsOption_reg == QS_OPT_SLOW)
                    begin
                        if (stopDone)
                            state_next = ST_SWITCH_ON_DISABLED; // see R17
                    end
                    else
                        state_next = ST_SWITCH_ON_DISABLED;   // see R17
                ST_FAULT_REACTION:
                    if (stopDone)
                        state_next = ST_FAULT;                // see R16
                ST_FAULT:
                    if (faultResetRise && !faultS)
                        state_next = ST_SWITCH_ON_DISABLED;   // see R21
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            state_reg <= ST_NOT_READY;                        // see R1
        else
            state_reg <= state_next;
    end

    // Stop request towards the motion block during quick stop
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            stopKind <= STOP_NONE;
        else if (state_next != ST_QUICK_STOP)
            stopKind <= STOP_NONE;
        else if (qsOption_reg == QS_OPT_QUICK || qsOption_reg == QS_OPT_QUICK_HOLD)
            stopKind <= STOP_QUICK;                           // see R18
        else if (qsOption_reg == QS_OPT_SLOW || qsOption_reg == QS_OPT_SLOW_HOLD)
            stopKind <= STOP_SLOW;                            // see R17
        else
            stopKind <= STOP_COAST;                           // see R17
    end

    // Energised is a request only; the power stage keeps its own authority
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            energised     <= 1'b0;
            faultReaction <= 1'b0;
        end
        else
        begin
            // Options 1 to 4 ramp under power; any other option coasts unpowered
            energised     <= (state_next == ST_OP_ENABLED) ||
                             (state_next == ST_QUICK_STOP && qsOption_reg - 16'h0001 < 16'h0004) ||
                             (state_next == ST_FAULT_REACTION);   // see R20
            faultReaction <= (state_next == ST_FAULT_REACTION);
        end
    end

    // Mode-specific control bits act only while operation is enabled, except relativeTarget, which follows bit 6 in any state
    logic opEn;
    logic modePP;
    logic modeHome;

    assign opEn     = (state_reg == ST_OP_ENABLED);
    assign modePP   = (modeOfOperation == MODE_PROFILE_POS);
    assign modeHome = (modeOfOperation == MODE_HOMING);

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            moveStart      <= 1'b0;
            setImmediate   <= 1'b0;
            relativeTarget <= 1'b0;
            homingStart    <= 1'b0;
            homingStop     <= 1'b0;
            haltRequest    <= 1'b0;
        end
        else
        begin
            moveStart      <= opEn && modePP && setptRise;                 // see R9
            setImmediate   <= opEn && modePP && ctrlWord_reg[CW_IMMEDIATE]; // see R9
            relativeTarget <= modePP && ctrlWord_reg[CW_RELATIVE];         // see R9
            homingStart    <= opEn && modeHome && setptRise;               // see R10
            homingStop     <= opEn && modeHome && setptFall;               // see R10
            haltRequest    <= opEn && ctrlWord_reg[CW_HALT];               // see R6
        end
    end

    // Status word, rebuilt every cycle from the current state
    logic mode12;
    logic mode13;

    always_comb
    begin
        mode12 = 1'b0;
        mode13 = 1'b0;
        unique case (modeOfOperation)
            MODE_PROFILE_POS:
            begin
                mode12 = setpointAck;
                mode13 = followingError;
            end
            MODE_HOMING:
            begin
                mode12 = homingAttained;
                mode13 = homingError;
            end
            MODE_INTERP:      mode12 = interpActive;
            MODE_PROFILE_VEL: mode12 = zeroSpeed;
            default:          mode12 = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            statusWord_reg <= 16'h0000;
        else
        begin
            statusWord_reg                   <= 16'h0000;
            statusWord_reg[6:0]              <= statePattern(state_reg); // see R13
            if (state_reg == ST_READY || state_reg == ST_SWITCHED_ON ||
                state_reg == ST_OP_ENABLED || state_reg == ST_QUICK_STOP)
                statusWord_reg[SP_VOLT_BIT]  <= 1'b1;                    // see R14
            statusWord_reg[SW_WARNING]       <= warning;                  // see R11
            statusWord_reg[SW_TARGET]        <= targetReached;            // see R11
            statusWord_reg[SW_MODE_12]       <= mode12;                   // see R12
            statusWord_reg[SW_MODE_13]       <= mode13;                   // see R12
        end
    end

    // Quick stop pattern clears bit 5; fault patterns come from the table
    assign statusWord = statusWord_reg;                       // see R15

    // Panel indication
    dsc_panel_if #(
        .FAULT_CODE_W (FAULT_CODE_W),
        .PANEL_SEL_W  (PANEL_SEL_W)
    ) panelBus ();

    assign panelBus.state     = state_reg;
    assign panelBus.faultCode = faultCode;
    assign panelBus.varSelect = panelVariableSelect;
    assign panelBus.varValue  = panelVariableValue;

    dsc_panel_display #(
        .FAULT_CODE_W (FAULT_CODE_W)
    ) panelEnc (
        .sys_clk (sys_clk),
        .reset   (reset),
        .pif     (panelBus.panel)
    );

    assign panelKind  = panelBus.panelKind;                   // see R3
    assign panelValue = panelBus.panelValue;                  // see R4
endmodule
`default_nettype wire

// *** test/dsc_master_model.sv ***
// Fieldbus master stand-in issuing one-cycle object requests.
// Assumes the drive acknowledges one cycle after taking a request.
`timescale 1ns/1ps
`default_nettype none
module dsc_master_model (
    input  wire logic        sys_clk,
    input  wire logic        objAck,
    input  wire logic [15:0] objReadData,
    output logic             objWrite,
    output logic             objRead,
    output logic [15:0]      objIndex,
    output logic [15:0]      objWriteData
);
    initial {objWrite, objRead, objIndex, objWriteData} = 34'h0;
    // Bench also sends an enable value out of legal order, to check that it is ignored
    task automatic xfer(input logic w, input logic [15:0] i, input logic [15:0] d,
                        output logic [15:0] q);
        @(negedge sys_clk);
        objWrite = w;
        objRead = !w;
        objIndex = i;
        objWriteData = d;
        @(negedge sys_clk);
        q = objAck ? objReadData : 16'hDEAD;
        objWrite = 1'b0;
        objRead = 1'b0;
        // Released lines show inverted values, never a stale copy
        objIndex = ~i;
        objWriteData = ~d;
    endtask
endmodule
`default_nettype wire

// *** test/dsc_state_props.sv ***
// Port checker for the drive state control block.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module dsc_state_props (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        objWrite,
    input wire logic        objRead,
    input wire logic        objAck,
    input wire logic [15:0] statusWord,
    input wire logic [1:0]  stopKind,
    input wire logic        faultReaction,
    input wire logic        energised,
    input wire logic        moveStart
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_ack_after_req: assert property ((objWrite || objRead) |=> objAck)
        else $error("request without ack");
    a_ack_only_req: assert property (objAck |-> $past(objWrite || objRead))
        else $error("ack without request");
    a_energised_status: assert property ($past(energised) |-> statusWord[2:0] == 3'h7)
        else $error("energised state not in status");
    a_fault_react: assert property ($past(faultReaction) |->
        statusWord[3:0] == 4'hF && !statusWord[6])
        else $error("fault reaction pattern wrong");
    a_quick_stop_pat: assert property ($past(stopKind) >= 2'd2 |->
        statusWord[5:0] == 6'h17)
        else $error("quick stop pattern wrong");
    a_move_pulse: assert property (moveStart |-> $past(energised) ##1 !moveStart)
        else $error("move start pulse wrong");
    a_ready_pat: assert property ((statusWord[3:0] == 4'h1 || statusWord[3:0] == 4'h3) |->
        statusWord[6:4] == 3'b011)
        else $error("ready pattern wrong");
    a_disabled_pat: assert property (statusWord[6] |-> statusWord[5:0] == 6'h00)
        else $error("disabled pattern wrong");
endmodule
bind dsc_drive_state_control dsc_state_props i_props (.sys_clk, .reset, .objWrite, .objRead,
    .objAck, .statusWord, .stopKind, .faultReaction, .energised, .moveStart);
`default_nettype wire

// *** test/drive_state_control_tb.sv ***
// Bench for drive state control against a status-pattern table model.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module drive_state_control_tb;
    import dsc_pkg::*;
    logic        sys_clk = 0, reset = 1, initDone = 0, faultPresent = 0, stopDone = 0;
    logic        objWrite, objRead, objAck, faultReaction, energised, moveStart, hwFault = 1;
    logic        setImmediate, relativeTarget, homingStart, homingStop, haltRequest;
    logic [15:0] objIndex, objWriteData, objReadData, statusWord, panelValue, q;
    logic [11:0] faultCode;
    logic [7:0]  rnd = 8'h00, sel = 8'h00;
    logic [2:0]  panelKind;
    logic [1:0]  stopKind;
    int          fail_count = 0, num_checks = 0;
    logic [6:0]  pat[8] = '{7'h00, 7'h40, 7'h31, 7'h33, 7'h37, 7'h17, 7'h0F, 7'h08};
    dsc_master_model i_mst (.sys_clk, .objAck, .objReadData, .objWrite, .objRead, .objIndex,
        .objWriteData);
    dsc_drive_state_control i_dut (.sys_clk, .reset, .objWrite, .objRead, .objIndex,
        .objWriteData, .objReadData, .objAck, .initDone, .hwFault, .faultPresent,
        .faultCode, .warning(rnd[0]), .modeOfOperation(MODE_PROFILE_POS),
        .targetReached(rnd[1]), .setpointAck(rnd[2]), .homingAttained(rnd[3]),
        .homingError(rnd[4]), .followingError(rnd[5]), .interpActive(rnd[6]),
        .zeroSpeed(rnd[7]), .stopDone, .panelVariableSelect(sel), .panelVariableValue(q),
        .statusWord, .stopKind, .faultReaction, .energised, .moveStart, .setImmediate,
        .relativeTarget, .homingStart, .homingStop, .haltRequest, .panelKind, .panelValue);
    function automatic logic [15:0] exp_sw(int s);
        return {2'b00, rnd[5], rnd[2], 1'b0, rnd[1], 2'b00, rnd[0], pat[s]};
    endfunction
    task automatic ctl(input logic [15:0] d, input int s);
        rnd = 8'($urandom);
        i_mst.xfer(1'b1, IDX_CONTROL, d, q);
        repeat (4) @(negedge sys_clk);
        `CHK(statusWord, exp_sw(s))
        i_mst.xfer(1'b0, IDX_STATUS, 16'h0000, q);
        `CHK(q, exp_sw(s))
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial forever #50 sys_clk = ~sys_clk;
    initial
    begin
        #2_000_000;
        fail_count++;
        end_sim();
    end
    initial
    begin
        void'($urandom(26374));
        faultCode = 12'($urandom);
        repeat (5) @(negedge sys_clk);
        `CHK(({statusWord, panelKind}), ({16'h0000, PANEL_RESET_IND}))
        reset = 0;
        initDone = 1;
        repeat (6) @(negedge sys_clk);
        `CHK(statusWord, exp_sw(0))
        hwFault = 0;
        repeat (6) @(negedge sys_clk);
        `CHK(statusWord, exp_sw(1))
        ctl(16'h000F, 1);
        ctl(16'h0006, 2);
        `CHK(panelKind, PANEL_READY_IND)
        ctl(16'h0007, 3);
        ctl(16'h000F, 4);
        `CHK(({panelKind, energised}), ({PANEL_RUN_IND, 1'b1}))
        sel = 8'h05;
        repeat (2) @(negedge sys_clk);
        `CHK(({panelKind, panelValue}), ({PANEL_VARIABLE, q}))
        sel = 8'h00;
        ctl(16'h015F, 4);
        `CHK(({relativeTarget, setImmediate, haltRequest}), 3'b101)
        ctl(16'h002F, 4);
        `CHK(({relativeTarget, setImmediate, haltRequest}), 3'b010)
        ctl(16'h0007, 3);
        for (int o = 0; o < 5; o++)
        begin
            i_mst.xfer(1'b1, IDX_QS_OPTION, 16'(o), q);
            i_mst.xfer(1'b0, IDX_QS_OPTION, 16'h0000, q);
            `CHK(q, 16'(o))
            ctl(16'h000F, 4);
            ctl(16'h0002, o == 0 ? 1 : 5);
            `CHK(stopKind, (o == 0 ? 2'd0 : 2'(3 - o % 2)))
            stopDone = 1;
            ctl(16'h0002, o < 3 ? 1 : 5);
            stopDone = 0;
            ctl(16'h0000, 1);
            ctl(16'h0006, 2);
            ctl(16'h0007, 3);
        end
        faultPresent = 1;
        repeat (5) @(negedge sys_clk);
        `CHK(({statusWord, faultReaction}), ({exp_sw(6), 1'b1}))
        stopDone = 1;
        repeat (4) @(negedge sys_clk);
        `CHK(({statusWord, panelKind, panelValue}), ({exp_sw(7), PANEL_FAULT_IND, 4'h0, faultCode}))
        ctl(16'h0080, 7);
        faultPresent = 0;
        ctl(16'h0000, 7);
        ctl(16'h0080, 1);
        i_mst.xfer(1'b0, 16'h1234, 16'h0000, q);
        `CHK(q, 16'h0000)
        end_sim();
    end
endmodule
`default_nettype wire
